// ### verilog/clkmgr_pkg.sv
// Constants shared by the clock manager control register block.
// Assumes an 8-bit register port with a 3-bit register index.
package clkmgr_pkg;

    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 8;
    localparam int          NUM_DIV         = 3;

    // Register indices.
    localparam logic [2:0]  OFS_DIV_IN      = 3'h0;
    localparam logic [2:0]  OFS_DIV_FB      = 3'h1;
    localparam logic [2:0]  OFS_DIV_FIO     = 3'h2;
    localparam logic [2:0]  OFS_DUTY_1X     = 3'h4;
    localparam logic [2:0]  OFS_MODE        = 3'h5;
    localparam logic [2:0]  OFS_SRC         = 3'h6;
    localparam logic [2:0]  OFS_CTRL        = 3'h7;

    // Writable bits of each register; the rest are reserved.
    localparam logic [7:0]  DIV_MASK        = 8'h8f;
    localparam logic [7:0]  MODE_MASK       = 8'h15;
    localparam logic [7:0]  SRC_MASK        = 8'hf0;
    localparam logic [7:0]  CTRL_MASK       = 8'hc7;

    // Reset values.
    localparam logic [7:0]  DUTY_RST        = 8'h00;
    localparam logic [7:0]  MODE_RST        = 8'h00;
    localparam logic [7:0]  SRC_RST         = 8'h00;
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [3:0]  DIV_VAL_RST     = 4'h0;

    // Field positions.
    localparam int          DIV_RST_BIT     = 7;
    localparam int          DIV_VAL_LSB     = 0;
    localparam int          MODE_PLL_BIT    = 0;
    localparam int          MODE_PDFB_BIT   = 2;
    localparam int          MODE_DBL_BIT    = 4;
    localparam int          SRC_FIO_LSB     = 4;
    localparam int          SRC_SYS_LSB     = 6;
    localparam int          CTRL_PWR_BIT    = 0;
    localparam int          CTRL_MRST_BIT   = 1;
    localparam int          CTRL_DRST_BIT   = 2;
    localparam int          CTRL_CFGEN_BIT  = 6;
    localparam int          CTRL_GSRBLK_BIT = 7;
    localparam int          DUTY_FLO_LSB    = 0;
    localparam int          DUTY_FHI_LSB    = 3;
    localparam int          DUTY_RNG_LSB    = 6;

    // Source codes.
    localparam logic [1:0]  SRC_BYPASS      = 2'h0;
    localparam logic [1:0]  SRC_LOOP        = 2'h1;
    localparam logic [1:0]  SRC_TAPPED      = 2'h2;
    localparam logic [1:0]  SRC_DIVIDED     = 2'h3;

    // Duty result is in 1/32 of the input period; one fine step is 3.125 %.
    localparam logic [5:0]  DUTY_STEP_ONE   = 6'h01;

endpackage : clkmgr_pkg

// ### verilog/duty_sel_if.sv
// Carries the 1x duty/delay selection byte and its decoded value.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface duty_sel_if;
    logic [7:0] sel;
    logic [5:0] value;
    modport host (output sel, input value);
    modport dec  (input sel, output value);
endinterface : duty_sel_if

// ### verilog/duty_decoder.sv
// Decodes the 1x duty/delay byte into a count of 1/32 input periods.
// Assumes a stable selection byte from the register block; purely combinational.
`timescale 1ns/1ps
module duty_decoder
    import clkmgr_pkg::*;
(
    duty_sel_if.dec ds
);
    logic [1:0] range;
    logic [2:0] fine;

    always_comb begin
        range = ds.sel[DUTY_RNG_LSB +: 2];
        // Only one fine field counts; the other is a don't care.
        if (range[1]) begin
            fine = ds.sel[DUTY_FHI_LSB +: 3];
        end else begin
            fine = ds.sel[DUTY_FLO_LSB +: 3];
        end
        // Range weighs 8/32 (25 %), each fine step 1/32 (3.125 %).
        ds.value = {1'b0, range, 3'b000} + {3'b000, fine} + DUTY_STEP_ONE;
    end

endmodule : duty_decoder

// ### verilog/clock_manager_control_regs.sv
// Control register set of the programmable clock manager.
// Assumes an 8-bit indexed register port shared by the configuration stream and
// user logic; done, global reset and lock arrive from other domains.
`timescale 1ns/1ps
module clock_manager_control_regs
    import clkmgr_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    rstn_i,
    input  wire logic [ADDR_W-1:0]       reg_addr_i,
    input  wire logic [DATA_W-1:0]       reg_wdata_i,
    input  wire logic                    reg_wr_i,
    output logic      [DATA_W-1:0]       reg_rdata_o,
    input  wire logic                    config_done_i,
    input  wire logic                    global_set_reset_n_i,
    input  wire logic                    lock_raw_i,
    output logic      [5:0]              duty_1x_o,
    output logic                         pll_mode_o,
    output logic                         pd_feedback_delay_o,
    output logic                         dll_double_o,
    output logic      [1:0]              fast_io_src_o,
    output logic      [1:0]              sys_clk_src_o,
    output logic                         analog_power_o,
    output logic                         manager_reset_o,
    output logic                         dll_reset_o,
    output logic                         out_bus_oe_o,
    output logic                         lock_o,
    output logic      [NUM_DIV-1:0][3:0] div_ratio_o,
    output logic      [NUM_DIV-1:0]      div_reset_o
);

    logic [7:0]              duty_reg;
    logic [7:0]              mode_reg;
    logic [7:0]              src_reg;
    logic [7:0]              ctrl_reg;
    logic [NUM_DIV-1:0][3:0] div_val;
    logic [NUM_DIV-1:0]      div_rst;
    logic [1:0]              done_sync;
    logic [1:0]              gsr_sync;
    logic [1:0]              lock_sync;
    logic                    done_s;
    logic                    gsr_active;
    logic                    gsr_hit;
    logic                    run_ok;
    logic                    mgr_rst;
    logic [7:0]              next_rdata;
    duty_sel_if              dsel ();

    // Pins from other domains pass two flops before any use.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_sync <= 2'b00;
            gsr_sync  <= 2'b11;
            lock_sync <= 2'b00;
        end else begin
            done_sync <= {done_sync[0], config_done_i};
            gsr_sync  <= {gsr_sync[0], global_set_reset_n_i};
            lock_sync <= {lock_sync[0], lock_raw_i};
        end
    end

    assign done_s     = done_sync[1];
    assign gsr_active = ~gsr_sync[1];
    assign gsr_hit    = gsr_active & ~ctrl_reg[CTRL_GSRBLK_BIT];
    assign run_ok     = done_s | ctrl_reg[CTRL_CFGEN_BIT];
    assign mgr_rst    = ctrl_reg[CTRL_MRST_BIT] | gsr_hit;

    // The byte is written as a whole; software picks which fine field counts.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            duty_reg <= DUTY_RST;
        end else if (reg_wr_i && reg_addr_i == OFS_DUTY_1X) begin
            duty_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg <= MODE_RST;
        end else if (reg_wr_i && reg_addr_i == OFS_MODE) begin
            mode_reg <= reg_wdata_i & MODE_MASK;
        end
    end

    // A write that asks for the reserved system source keeps the old code, so the
    // output never reaches an undefined selector setting.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_reg <= SRC_RST;
        end else if (reg_wr_i && reg_addr_i == OFS_SRC) begin
            src_reg[SRC_FIO_LSB +: 2] <= reg_wdata_i[SRC_FIO_LSB +: 2];
            if (reg_wdata_i[SRC_SYS_LSB +: 2] != SRC_DIVIDED) begin
                src_reg[SRC_SYS_LSB +: 2] <= reg_wdata_i[SRC_SYS_LSB +: 2];
            end
            src_reg[3:0] <= 4'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= CTRL_RST;
        end else if (reg_wr_i && reg_addr_i == OFS_CTRL) begin
            ctrl_reg <= reg_wdata_i & CTRL_MASK;
        end
    end

    // Dividers: the global reset returns them to default unless it is blocked.
    for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                div_val[g] <= DIV_VAL_RST;
                div_rst[g] <= 1'b0;
            end else if (gsr_hit) begin
                div_val[g] <= DIV_VAL_RST;
                div_rst[g] <= 1'b0;
            end else if (reg_wr_i && reg_addr_i == 3'(g)) begin
                div_val[g] <= reg_wdata_i[DIV_VAL_LSB +: 4];
                div_rst[g] <= reg_wdata_i[DIV_RST_BIT];
            end
        end

        // Values above 8 fold to modulo 8; 0 means bypass; 8 stays 8.
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                div_ratio_o[g] <= DIV_VAL_RST;
                div_reset_o[g] <= 1'b0;
            end else begin
                if (div_val[g][3] && div_val[g][2:0] != 3'h0) begin
                    div_ratio_o[g] <= {1'b0, div_val[g][2:0]};
                end else begin
                    div_ratio_o[g] <= div_val[g];
                end
                div_reset_o[g] <= div_rst[g] | mgr_rst;
            end
        end
    end

    assign dsel.sel = duty_reg;

    duty_decoder u_duty (
        .ds (dsel)
    );

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            duty_1x_o <= 6'h00;
        end else begin
            duty_1x_o <= dsel.value;
        end
    end

    // Mode outputs: a bit without effect in the current mode is forced inactive.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_mode_o          <= 1'b0;
            pd_feedback_delay_o <= 1'b0;
            dll_double_o        <= 1'b0;
        end else begin
            pll_mode_o          <= mode_reg[MODE_PLL_BIT];
            pd_feedback_delay_o <= mode_reg[MODE_PDFB_BIT] & mode_reg[MODE_PLL_BIT];
            dll_double_o        <= mode_reg[MODE_DBL_BIT] & ~mode_reg[MODE_PLL_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fast_io_src_o <= SRC_BYPASS;
            sys_clk_src_o <= SRC_BYPASS;
        end else begin
            fast_io_src_o <= src_reg[SRC_FIO_LSB +: 2];
            sys_clk_src_o <= src_reg[SRC_SYS_LSB +: 2];
        end
    end

    // Power, resets and configuration gating.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            analog_power_o  <= 1'b0;
            manager_reset_o <= 1'b0;
            dll_reset_o     <= 1'b0;
            out_bus_oe_o    <= 1'b0;
            lock_o          <= 1'b0;
        end else begin
            analog_power_o  <= ctrl_reg[CTRL_PWR_BIT] & run_ok;
            manager_reset_o <= mgr_rst;
            dll_reset_o     <= ctrl_reg[CTRL_DRST_BIT] | mgr_rst;
            out_bus_oe_o    <= run_ok;
            lock_o          <= lock_sync[1] & run_ok & ~mgr_rst;
        end
    end

    // Read-back: unmapped indices and reserved bits read as zero.
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            OFS_DIV_IN:  next_rdata = {div_rst[0], 3'b000, div_val[0]};
            OFS_DIV_FB:  next_rdata = {div_rst[1], 3'b000, div_val[1]};
            OFS_DIV_FIO: next_rdata = {div_rst[2], 3'b000, div_val[2]};
            OFS_DUTY_1X: next_rdata = duty_reg;
            OFS_MODE:    next_rdata = mode_reg & MODE_MASK;
            OFS_SRC:     next_rdata = src_reg & SRC_MASK;
            OFS_CTRL:    next_rdata = ctrl_reg & CTRL_MASK;
            default:     next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    chk_duty_low_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !duty_reg[7] |=> duty_1x_o == {1'b0, $past(duty_reg[7:6]), 3'b000} + {3'b000, $past(duty_reg[2:0])} + 6'h01)
        else $error("Low duty selection decoded wrongly.");

    chk_duty_high_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
        duty_reg[7] |=> duty_1x_o == {1'b0, $past(duty_reg[7:6]), 3'b000} + {3'b000, $past(duty_reg[5:3])} + 6'h01)
        else $error("High duty selection decoded wrongly.");

    chk_duty_band: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $stable(duty_reg) |=> (duty_1x_o > {1'b0, $past(duty_reg[7:6]), 3'b000})
                              && (duty_1x_o <= {1'b0, $past(duty_reg[7:6]), 3'b000} + 6'h08))
        else $error("Duty result outside its band.");

    chk_fine_ignored: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $past(rstn_i) && (duty_reg[7] ? $stable(duty_reg[7:3]) : $stable(duty_reg[7:6]) && $stable(duty_reg[2:0]))
        |=> $stable(duty_1x_o))
        else $error("Unselected fine field changed the duty result.");

    chk_mode_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == OFS_MODE) |=> ##1 pll_mode_o == $past(reg_wdata_i[0], 2))
        else $error("Mode write did not reach the loop select.");

    chk_pd_feedback: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !pll_mode_o |-> !pd_feedback_delay_o)
        else $error("Detector feedback select active in delay mode.");

    chk_double_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pll_mode_o |-> !dll_double_o)
        else $error("Doubled output active in phase mode.");

    chk_sys_reserved: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sys_clk_src_o != SRC_DIVIDED)
        else $error("Reserved system clock source selected.");

    chk_power_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!done_s && !ctrl_reg[CTRL_CFGEN_BIT]) |=> !analog_power_o && !out_bus_oe_o && !lock_o)
        else $error("Manager active during configuration.");

    chk_supply_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !ctrl_reg[CTRL_PWR_BIT] |=> !analog_power_o)
        else $error("Analog supply on with switch off.");

    chk_manager_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl_reg[CTRL_MRST_BIT] |=> manager_reset_o && dll_reset_o && (&div_reset_o))
        else $error("Manager reset did not reach all logic.");

    chk_gsr_blocked: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ctrl_reg[CTRL_GSRBLK_BIT] && !ctrl_reg[CTRL_MRST_BIT]) |=> !manager_reset_o)
        else $error("Blocked global reset reached the manager.");

    chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mode_reg & ~MODE_MASK) == 8'h00 && (ctrl_reg & ~CTRL_MASK) == 8'h00 && src_reg[3:0] == 4'h0)
        else $error("Reserved bits hold a nonzero value.");

    chk_pd_feedback_pass: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mode_reg[MODE_PLL_BIT] |=> pd_feedback_delay_o == $past(mode_reg[MODE_PDFB_BIT]))
        else $error("Detector feedback select lost in phase mode.");

    chk_double_pass: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !mode_reg[MODE_PLL_BIT] |=> dll_double_o == $past(mode_reg[MODE_DBL_BIT]))
        else $error("Doubled output select lost in delay mode.");

    chk_fio_src_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == OFS_SRC) |=> ##1 fast_io_src_o == $past(reg_wdata_i[SRC_FIO_LSB +: 2], 2))
        else $error("Fast clock source write did not reach the output.");

    chk_sys_src_keep: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == OFS_SRC && reg_wdata_i[SRC_SYS_LSB +: 2] == SRC_DIVIDED)
        |=> ##1 sys_clk_src_o == $past(src_reg[SRC_SYS_LSB +: 2], 2))
        else $error("Reserved system source write changed the output.");

    chk_power_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ctrl_reg[CTRL_PWR_BIT] && run_ok) |=> analog_power_o)
        else $error("Analog supply off with switch on.");

    chk_dll_reset_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl_reg[CTRL_DRST_BIT] |=> dll_reset_o)
        else $error("Delay loop reset not driven.");

    chk_dll_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ctrl_reg[CTRL_DRST_BIT] && !mgr_rst) |=> !manager_reset_o && div_reset_o == $past(div_rst))
        else $error("Delay loop reset touched other logic.");

    chk_bus_oe_done: assert property (@(posedge clk_i) disable iff (!rstn_i)
        done_s |=> out_bus_oe_o)
        else $error("Output bus still off after configuration.");

    chk_run_config: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl_reg[CTRL_CFGEN_BIT] |=> out_bus_oe_o)
        else $error("Manager blocked during configuration though enabled.");

    chk_gsr_reaches: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (gsr_active && !ctrl_reg[CTRL_GSRBLK_BIT]) |=> manager_reset_o)
        else $error("Unblocked global reset did not reach the manager.");

    chk_lock_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mgr_rst |=> !lock_o)
        else $error("Lock shown while the manager is held in reset.");

    chk_div_gsr_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        gsr_hit |=> (div_val == '0) && (div_rst == '0))
        else $error("Global reset did not clear the dividers.");

    chk_div_own_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == OFS_DIV_IN && !gsr_hit) |=> div_rst[0] == $past(reg_wdata_i[DIV_RST_BIT]))
        else $error("Divider reset bit not written.");

    chk_readback_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_addr_i == OFS_MODE) |=> (reg_rdata_o & ~MODE_MASK) == 8'h00)
        else $error("Reserved mode bits read back nonzero.");

    chk_readback_ctrl: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_addr_i == OFS_CTRL) |=> (reg_rdata_o & ~CTRL_MASK) == 8'h00)
        else $error("Reserved control bits read back nonzero.");

endmodule : clock_manager_control_regs

// ### verification/cfg_fabric_model.sv
// Behavioural model of the configuration logic and fabric around the clock manager.
// Assumes one clock; the bench asks for global resets, done and lock follow fixed delays.
`timescale 1ns/1ps
module cfg_fabric_model #(
    parameter int DONE_DLY = 80,
    parameter int LOCK_DLY = 10
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic power_i,
    input  wire logic gsr_req_i,
    output logic      done_o,
    output logic      gsr_n_o,
    output logic      lock_o
);
    int done_cnt;
    int lock_cnt;

    // Configuration ends once after a fixed time and done then stays high.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_cnt <= 0;
            done_o   <= 1'b0;
        end else if (done_cnt < DONE_DLY) begin
            done_cnt <= done_cnt + 1;
        end else begin
            done_o <= 1'b1;
        end
    end

    // The loop only locks while its supply is on, and loses lock at the next clock edge after it goes off.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i || !power_i) begin
            lock_cnt <= 0;
            lock_o   <= 1'b0;
        end else if (lock_cnt < LOCK_DLY) begin
            lock_cnt <= lock_cnt + 1;
        end else begin
            lock_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gsr_n_o <= 1'b1;
        end else begin
            gsr_n_o <= !gsr_req_i;
        end
    end
endmodule : cfg_fabric_model

// ### verification/clock_manager_control_regs_bench.sv
// Self-checking bench for the clock manager control registers.
// Assumes the register port contract of the block; inputs change at the falling edge.
`timescale 1ns/1ps
module clock_manager_control_regs_bench;
    import clkmgr_pkg::*;
    logic                    clk_i;
    logic                    rstn_i;
    logic [ADDR_W-1:0]       reg_addr_i;
    logic [DATA_W-1:0]       reg_wdata_i;
    logic                    reg_wr_i;
    logic [DATA_W-1:0]       reg_rdata_o;
    logic                    done;
    logic                    gsr_n;
    logic                    lock_raw;
    logic                    gsr_req;
    logic [5:0]              duty_1x_o;
    logic                    pll_mode_o;
    logic                    pd_feedback_delay_o;
    logic                    dll_double_o;
    logic [1:0]              fast_io_src_o;
    logic [1:0]              sys_clk_src_o;
    logic                    analog_power_o;
    logic                    manager_reset_o;
    logic                    dll_reset_o;
    logic                    out_bus_oe_o;
    logic                    lock_o;
    logic [NUM_DIV-1:0][3:0] div_ratio_o;
    logic [NUM_DIV-1:0]      div_reset_o;
    int                      errors;
    int                      num_checks;
    int                      cycles;
    logic [7:0]              duty_tab [5] = '{8'h4c, 8'hf0, 8'hff, 8'h97, 8'h38};

    clock_manager_control_regs u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
        .config_done_i(done), .global_set_reset_n_i(gsr_n), .lock_raw_i(lock_raw),
        .duty_1x_o(duty_1x_o), .pll_mode_o(pll_mode_o), .pd_feedback_delay_o(pd_feedback_delay_o),
        .dll_double_o(dll_double_o), .fast_io_src_o(fast_io_src_o), .sys_clk_src_o(sys_clk_src_o),
        .analog_power_o(analog_power_o), .manager_reset_o(manager_reset_o), .dll_reset_o(dll_reset_o),
        .out_bus_oe_o(out_bus_oe_o), .lock_o(lock_o), .div_ratio_o(div_ratio_o),
        .div_reset_o(div_reset_o));

    cfg_fabric_model u_far (.clk_i(clk_i), .rstn_i(rstn_i), .power_i(analog_power_o),
        .gsr_req_i(gsr_req), .done_o(done), .gsr_n_o(gsr_n), .lock_o(lock_raw));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // The run should take under a thousand cycles; a hang is cut short well beyond that.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            report_and_stop();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : idle

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1'b1;
        idle(1);
        reg_wr_i    = 1'b0;
        // A full low cycle keeps back-to-back writes from toggling the strobe twice at once.
        idle(1);
    endtask : wr

    // Read data shows the register addressed one edge earlier.
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        reg_addr_i = a;
        idle(2);
        chk("rdata", exp, reg_rdata_o);
    endtask : rd

    function automatic logic [7:0] duty_exp(input logic [7:0] b);
        return 8'({b[7:6], 3'h0}) + 8'(b[7] ? b[5:3] : b[2:0]) + 8'h01;
    endfunction : duty_exp

    initial begin
        errors = 0;
        num_checks = 0;
        cycles = 0;
        rstn_i = 1'b0;
        reg_addr_i = 3'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        gsr_req = 1'b0;
        idle(12);
        rstn_i = 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        wr(OFS_CTRL, 8'h01);
        idle(4);
        chk("power", 8'h00, 8'(analog_power_o));
        chk("bus_oe", 8'h00, 8'(out_bus_oe_o));
        chk("lock", 8'h00, 8'(lock_o));
        wr(OFS_CTRL, 8'h41);
        idle(4);
        chk("power", 8'h01, 8'(analog_power_o));
        chk("bus_oe", 8'h01, 8'(out_bus_oe_o));
        idle(16);
        chk("lock", 8'h01, 8'(lock_o));
        idle(40);
        wr(OFS_CTRL, 8'h01);
        idle(4);
        chk("power", 8'h01, 8'(analog_power_o));
        chk("bus_oe", 8'h01, 8'(out_bus_oe_o));
        wr(OFS_CTRL, 8'h00);
        idle(6);
        chk("power", 8'h00, 8'(analog_power_o));
        chk("lock", 8'h00, 8'(lock_o));
        foreach (duty_tab[i]) begin
            wr(OFS_DUTY_1X, duty_tab[i]);
            idle(1);
            chk("duty", duty_exp(duty_tab[i]), 8'(duty_1x_o));
            rd(OFS_DUTY_1X, duty_tab[i]);
        end
        wr(OFS_MODE, 8'hff);
        idle(1);
        chk("mode", 8'h06, 8'({pll_mode_o, pd_feedback_delay_o, dll_double_o}));
        rd(OFS_MODE, 8'h15);
        wr(OFS_MODE, 8'h14);
        idle(1);
        chk("mode", 8'h01, 8'({pll_mode_o, pd_feedback_delay_o, dll_double_o}));
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SRC, {2'(i), 2'(i), 4'hf});
            idle(1);
            chk("fio_src", 8'(i), 8'(fast_io_src_o));
            chk("sys_src", (i == 3) ? 8'h02 : 8'(i), 8'(sys_clk_src_o));
            rd(OFS_SRC, {(i == 3) ? 2'h2 : 2'(i), 2'(i), 4'h0});
        end
        wr(OFS_DIV_IN, 8'hf9);
        wr(OFS_DIV_FB, 8'h08);
        wr(OFS_DIV_FIO, 8'h03);
        idle(1);
        chk("ratio0", 8'h01, 8'(div_ratio_o[0]));
        chk("ratio1", 8'h08, 8'(div_ratio_o[1]));
        chk("ratio2", 8'h03, 8'(div_ratio_o[2]));
        chk("div_rst", 8'h01, 8'(div_reset_o));
        rd(OFS_DIV_IN, 8'h89);
        wr(OFS_CTRL, 8'h02);
        idle(1);
        chk("resets", 8'h1f, 8'({manager_reset_o, dll_reset_o, div_reset_o}));
        wr(OFS_CTRL, 8'hbc);
        idle(1);
        chk("resets", 8'h09, 8'({manager_reset_o, dll_reset_o, div_reset_o}));
        rd(OFS_DIV_FB, 8'h08);
        rd(OFS_CTRL, 8'h84);
        gsr_req = 1'b1;
        idle(5);
        chk("mgr_rst", 8'h00, 8'(manager_reset_o));
        chk("ratio1", 8'h08, 8'(div_ratio_o[1]));
        gsr_req = 1'b0;
        wr(OFS_CTRL, 8'h00);
        gsr_req = 1'b1;
        idle(5);
        chk("mgr_rst", 8'h01, 8'(manager_reset_o));
        chk("ratio1", 8'h00, 8'(div_ratio_o[1]));
        wr(OFS_DIV_FB, 8'h05);
        gsr_req = 1'b0;
        idle(5);
        rd(OFS_DIV_FB, 8'h00);
        chk("mgr_rst", 8'h00, 8'(manager_reset_o));
        wr(3'h3, 8'hff);
        rd(3'h3, 8'h00);
        report_and_stop();
    end
endmodule : clock_manager_control_regs_bench
